// ---- dv/tpg_gpio_tb_top.sv ----
module tpg_gpio_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tpg_pkg::*;
  logic clk, rst_i, por_i, hsel, hwrite, hready, hresp, t0clk, flag, wake;
  logic [7:0] haddr, pb_in, pb_out, pb_oe_n, pb_pu, per_en, per_oe, per_out, pb_ext, pb_ext_en;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, v;
  logic [4:0] pa_in, pa_out, pa_oe_n, pa_ext;
  logic [3:0] pa_ana;
  int error_cnt, tests_run, cyc;
  // ----------------------------------------------------------------
  // Design, pins and clock
  // ----------------------------------------------------------------
  tpg_gpio i_dut (.clk_i(clk), .rst_i(rst_i), .por_i(por_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .pa_in_i(pa_in), .pa_out_o(pa_out), .pa_oe_n_o(pa_oe_n),
    .pa_analog_sel_o(pa_ana), .pb_in_i(pb_in), .pb_out_o(pb_out), .pb_oe_n_o(pb_oe_n), .pb_pullup_o(pb_pu),
    .pb_per_en_i(per_en), .pb_per_oe_i(per_oe), .pb_per_out_i(per_out), .timer_zero_ext_clock_in_o(t0clk),
    .port_change_flag_o(flag), .wake_o(wake));
  tpg_pin_model i_pins (.clk_i(clk), .pa_out_i(pa_out), .pa_oe_n_i(pa_oe_n), .pb_out_i(pb_out),
    .pb_oe_n_i(pb_oe_n), .pb_pullup_i(pb_pu), .pa_ext_i(pa_ext), .pb_ext_i(pb_ext), .pb_ext_en_i(pb_ext_en),
    .pa_pin_o(pa_in), .pb_pin_o(pb_in));
  // 250 MHz clock
  always #2 clk = ~clk;
  // Hang guard: the tests need well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= TPG_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= TPG_HSIZE_WORD;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask : wr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, v);
    chk(v, e);
  endtask : rchk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(32'(pa_oe_n), 32'h1F);
    chk(32'(pa_ana), 32'hF);
    chk(32'(pb_pu), 32'h0);
    chk(32'(pb_oe_n), 32'hFF);
    rchk(TPG_OFF_PORT_A_DIR, 32'h1F);
    rchk(TPG_OFF_PORT_B_DIR, 32'hFF);
    rchk(TPG_OFF_ANALOG_CFG, 32'h0);
    rchk(TPG_OFF_PORT_A_DATA, 32'h10);
    rchk(8'h40, 32'h0);
    chk(32'(hresp), 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_port_a();
    wr(TPG_OFF_ANALOG_CFG, 32'(TPG_CFG_ALL_DIGITAL));
    wr(TPG_OFF_PORT_A_DATA, 32'h0A);
    wr(TPG_OFF_PORT_A_DIR, 32'h0);
    wt(3);
    chk(32'(pa_ana), 32'h0);
    chk(32'(pa_oe_n), 32'h0);
    chk(32'(pa_out), 32'h0A);
    wt(6);
    rchk(TPG_OFF_PORT_A_DATA, 32'h0A);
    wr(TPG_OFF_PORT_A_DATA, 32'h10);
    wt(3);
    chk(32'(pa_oe_n), 32'h10);
    chk(32'(pa_out), 32'h0);
    wr(TPG_OFF_PORT_A_DIR, 32'h1F);
    pa_ext <= 5'h15;
    wr(TPG_OFF_PERIPH, 32'h1);
    wt(6);
    rchk(TPG_OFF_PORT_A_DATA, 32'h15);
    chk(32'(t0clk), 32'h1);
    pa_ext <= 5'h05;
    wt(6);
    chk(32'(t0clk), 32'h0);
    wr(TPG_OFF_ANALOG_CFG, 32'h0);
    wr(TPG_OFF_PORT_A_DIR, 32'h1E);
    wt(6);
    chk(32'(pa_oe_n), 32'h1E);
    rchk(TPG_OFF_PORT_A_DATA, 32'h0);
    wr(TPG_OFF_PORT_A_DIR, 32'h1F);
    $display("test port a done");
  endtask : t_port_a
  task automatic t_pullup();
    wr(TPG_OFF_PORT_B_DATA, 32'h05);
    wr(TPG_OFF_PORT_B_DIR, 32'hF0);
    pb_ext_en <= 8'h0F;
    wr(TPG_OFF_OPTION, 32'h7F);
    wt(6);
    chk(32'(pb_oe_n), 32'hF0);
    chk(32'(pb_pu), 32'hF0);
    rchk(TPG_OFF_PORT_B_DATA, 32'hF5);
    pb_ext <= 8'hF0;
    pb_ext_en <= 8'hFF;
    wr(TPG_OFF_OPTION, 32'hFF);
    wt(3);
    chk(32'(pb_pu), 32'h0);
    $display("test pullup done");
  endtask : t_pullup
  task automatic t_change();
    wr(TPG_OFF_PORT_B_DIR, 32'hBF);
    wt(6);
    rchk(TPG_OFF_PORT_B_DATA, 32'hB0);
    wr(TPG_OFF_INT_CTRL, 32'h08);
    wr(TPG_OFF_PORT_B_DATA, 32'h40);
    pb_ext <= 8'hF1;
    wt(8); // waits without polling port B
    chk(32'(flag), 32'h0);
    chk(32'(pb_out), 32'h40);
    pb_ext <= 8'hD1;
    wt(8);
    chk(32'(flag), 32'h1);
    chk(32'(wake), 32'h1);
    wr(TPG_OFF_INT_CTRL, 32'h08);
    wt(3);
    chk(32'(flag), 32'h1);
    rchk(TPG_OFF_PORT_B_DATA, 32'hD1);
    wr(TPG_OFF_INT_CTRL, 32'h08);
    wt(3);
    chk(32'(flag), 32'h0);
    chk(32'(wake), 32'h0);
    $display("test change done");
  endtask : t_change
  task automatic t_override();
    per_en <= 8'h41; // direction register left untouched while overridden
    per_oe <= 8'h01;
    per_out <= 8'h01;
    wt(3);
    chk(32'(pb_oe_n), 32'hFE);
    chk(32'(pb_out[0]), 32'h1);
    per_en <= 8'h00;
    wt(3);
    chk(32'(pb_oe_n), 32'hBF);
    $display("test override done");
  endtask : t_override
  task automatic t_warm();
    wr(TPG_OFF_PORT_A_DATA, 32'h0B);
    rst_i <= 1'b1;
    por_i <= 1'b0;
    wt(2);
    rst_i <= 1'b0;
    wt(1);
    chk(32'(pa_oe_n), 32'h1F);
    rchk(TPG_OFF_PORT_A_DIR, 32'h1F);
    rchk(TPG_OFF_PORT_B_DIR, 32'hFF);
    wr(TPG_OFF_PORT_A_DIR, 32'h0);
    wt(3);
    chk(32'(pa_out), 32'h0B);
    $display("test warm reset done");
  endtask : t_warm
  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    rst_i = 1'b1;
    por_i = 1'b1;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {per_en, per_oe, per_out, pb_ext} = '0;
    pb_ext_en = 8'hFF;
    pa_ext = 5'h1F;
    wt(3);
    rst_i <= 1'b0;
    wt(6);
    t_reset();
    t_port_a();
    t_pullup();
    t_change();
    t_override();
    t_warm();
    summarize();
  end
endmodule : tpg_gpio_tb_top

// ---- dv/tpg_pin_model.sv ----
// Outside world of the pins: resolves each wire from all parties that drive it
module tpg_pin_model (
  // Design side
  input wire logic clk_i,
  input wire logic [4:0] pa_out_i,
  input wire logic [4:0] pa_oe_n_i,
  input wire logic [7:0] pb_out_i,
  input wire logic [7:0] pb_oe_n_i,
  input wire logic [7:0] pb_pullup_i,
  // External sources
  input wire logic [4:0] pa_ext_i,
  input wire logic [7:0] pb_ext_i,
  input wire logic [7:0] pb_ext_en_i,
  // Resolved levels
  output logic [4:0] pa_pin_o,
  output logic [7:0] pb_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pb_last_q;
  // An enabled driver wins; a floating line keeps no value, so it toggles
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pa_pin_o[i] = pa_oe_n_i[i] ? pa_ext_i[i] : pa_out_i[i];
    end
    for (int i = 0; i < 8; i++) begin
      if (!pb_oe_n_i[i]) pb_pin_o[i] = pb_out_i[i];
      else if (pb_ext_en_i[i]) pb_pin_o[i] = pb_ext_i[i];
      else if (pb_pullup_i[i]) pb_pin_o[i] = 1'b1;
      else pb_pin_o[i] = ~pb_last_q[i];
    end
  end
  // Last level, used only to make a floating line wander
  always_ff @(posedge clk_i) pb_last_q <= pb_pin_o;
endmodule : tpg_pin_model

// ---- logic/tpg_gpio.sv ----
// What this block does
// - Port A has five pins; direction one is input, zero drives latch.
// - Data reads return pin levels; writes go to the output latch.
// - Writes store the low bus bits, one per pin, in the latch; pins are not read.
// - Port A pin four feeds timer zero clock; output drives low only.
// - Port A pins 3:0 analog or digital per config field.
// - After power-up reset, analog pins are analog and read as zero.
// - Direction bits still rule analog pins; outputs drive the latch.
// - Port A direction resets to ones; latch kept over non-power resets.
// - Unimplemented register bits read as zero.
// - Port B has eight pins with the same direction meaning.
// - One active-low option bit enables all port B pull-ups.
// - A port B pin's pull-up is off while it is an output.
// - Power-up reset disables port B pull-ups.
// - An enabled peripheral overrides the direction of its pin.
// - A pin owned by an enabled peripheral stops being general I/O.
// - Only input pins among port B 7:4 join change detection.
// - Inputs compare against last-read values; mismatches OR into flag.
// - Mismatch keeps setting the flag; read port B, then clear.
// - The port change event can wake the device from sleep.
module tpg_gpio (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Port A pins
  input wire logic [tpg_pkg::TPG_A_W-1:0] pa_in_i,
  output logic [tpg_pkg::TPG_A_W-1:0] pa_out_o,
  output logic [tpg_pkg::TPG_A_W-1:0] pa_oe_n_o,
  output logic [tpg_pkg::TPG_ANA_PINS-1:0] pa_analog_sel_o,
  // Port B pins
  input wire logic [tpg_pkg::TPG_B_W-1:0] pb_in_i,
  output logic [tpg_pkg::TPG_B_W-1:0] pb_out_o,
  output logic [tpg_pkg::TPG_B_W-1:0] pb_oe_n_o,
  output logic [tpg_pkg::TPG_B_W-1:0] pb_pullup_o,
  // Port B peripheral overrides
  input wire logic [tpg_pkg::TPG_B_W-1:0] pb_per_en_i,
  input wire logic [tpg_pkg::TPG_B_W-1:0] pb_per_oe_i,
  input wire logic [tpg_pkg::TPG_B_W-1:0] pb_per_out_i,
  // Alternate functions and events
  output logic timer_zero_ext_clock_in_o,
  output logic port_change_flag_o,
  output logic wake_o
);
  import tpg_pkg::*;

  localparam int AW = TPG_A_W;
  localparam int BW = TPG_B_W;

  typedef struct packed {
    logic [AW-1:0] a_latch;
    logic [AW-1:0] a_dir;
    logic [TPG_CFG_W-1:0] cfg;
    logic [BW-1:0] b_latch;
    logic [BW-1:0] b_dir;
    logic [7:0] option;
    logic flag;
    logic int_en;
    logic t0_en;
    logic [3:0] b_old;
    logic pend;
    logic hwr;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [AW-1:0] a_out;
    logic [AW-1:0] a_oe_n;
    logic [TPG_ANA_PINS-1:0] ana;
    logic [BW-1:0] b_out;
    logic [BW-1:0] b_oe_n;
    logic [BW-1:0] pull;
    logic t0ck;
    logic wake;
  } tpg_state_t;

  tpg_state_t st_q, st_d;
  logic [AW-1:0] pa_sync;
  logic [BW-1:0] pb_sync;
  logic [AW-1:0] pa_read;
  logic [TPG_ANA_PINS-1:0] ana_mask;
  logic [3:0] mismatch;
  logic [AW-1:0] a_dir_eff;
  logic [BW-1:0] b_dir_eff;
  logic [BW-1:0] b_out_eff;
  logic wr_now;
  logic rd_now;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  tpg_sync3 #(.W(AW)) u_sync_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pa_in_i),
    .q_o(pa_sync)
  );

  tpg_sync3 #(.W(BW)) u_sync_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pb_in_i),
    .q_o(pb_sync)
  );

  // ----------------------------------------------------------------
  // Pin view
  // ----------------------------------------------------------------
  always_comb begin
    // Config 000 puts all four low pins in analog mode; only 110 frees them all
    for (int i = 0; i < TPG_ANA_PINS; i++) begin
      ana_mask[i] = (st_q.cfg != TPG_CFG_ALL_DIGITAL);
    end
    pa_read = pa_sync;
    pa_read[TPG_ANA_PINS-1:0] = pa_sync[TPG_ANA_PINS-1:0] & ~ana_mask;
    // Direction still applies in analog mode
    a_dir_eff = st_q.a_dir;
    // Peripheral owns its pin while enabled
    b_dir_eff = (st_q.b_dir & ~pb_per_en_i) | (~pb_per_oe_i & pb_per_en_i);
    b_out_eff = (st_q.b_latch & ~pb_per_en_i) | (pb_per_out_i & pb_per_en_i);
    // Only input pins among the upper four join the compare
    mismatch = (pb_sync[7:4] ^ st_q.b_old) & b_dir_eff[7:4];
  end

  // Bus strobes, taken in the data phase
  assign wr_now = st_q.pend && st_q.hwr;
  assign rd_now = st_q.pend && !st_q.hwr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.hwr = hwrite_i;
    st_d.pend = hsel_i && hready_i && htrans_i == TPG_HTRANS_NONSEQ && hsize_i == TPG_HSIZE_WORD;
    if (st_d.pend) begin
      st_d.addr = haddr_i;
    end
    // Whole-word write: the latch takes the low bits of the bus word, one per pin
    if (wr_now) begin
      if (st_q.addr == TPG_OFF_PORT_A_DATA) begin
        st_d.a_latch = hwdata_i[AW-1:0];
      end else if (st_q.addr == TPG_OFF_PORT_A_DIR) begin
        st_d.a_dir = hwdata_i[AW-1:0];
      end else if (st_q.addr == TPG_OFF_ANALOG_CFG) begin
        st_d.cfg = hwdata_i[TPG_CFG_W-1:0];
      end else if (st_q.addr == TPG_OFF_PORT_B_DATA) begin
        st_d.b_latch = hwdata_i[BW-1:0];
      end else if (st_q.addr == TPG_OFF_PORT_B_DIR) begin
        st_d.b_dir = hwdata_i[BW-1:0];
      end else if (st_q.addr == TPG_OFF_OPTION) begin
        st_d.option = hwdata_i[7:0];
      end else if (st_q.addr == TPG_OFF_INT_CTRL) begin
        st_d.flag = hwdata_i[TPG_INT_FLAG_BIT];
        st_d.int_en = hwdata_i[TPG_INT_EN_BIT];
      end else if (st_q.addr == TPG_OFF_PERIPH) begin
        st_d.t0_en = hwdata_i[TPG_PER_T0_BIT];
      end
    end
    // Port B read re-latches the compare reference
    if (rd_now && st_q.addr == TPG_OFF_PORT_B_DATA) begin
      st_d.b_old = pb_sync[7:4];
    end
    // Set beats clear; a lasting mismatch sets it again
    if (|mismatch) begin
      st_d.flag = 1'b1;
    end
    // Read data, registered for the next cycle; unused bits are zero
    st_d.rdata = '0;
    if (st_d.pend && !hwrite_i) begin
      if (haddr_i == TPG_OFF_PORT_A_DATA) begin
        st_d.rdata[AW-1:0] = pa_read;
      end else if (haddr_i == TPG_OFF_PORT_A_DIR) begin
        st_d.rdata[AW-1:0] = st_q.a_dir;
      end else if (haddr_i == TPG_OFF_ANALOG_CFG) begin
        st_d.rdata[TPG_CFG_W-1:0] = st_q.cfg;
      end else if (haddr_i == TPG_OFF_PORT_B_DATA) begin
        st_d.rdata[BW-1:0] = pb_sync;
      end else if (haddr_i == TPG_OFF_PORT_B_DIR) begin
        st_d.rdata[BW-1:0] = st_q.b_dir;
      end else if (haddr_i == TPG_OFF_OPTION) begin
        st_d.rdata[7:0] = st_q.option;
      end else if (haddr_i == TPG_OFF_INT_CTRL) begin
        st_d.rdata[TPG_INT_FLAG_BIT] = st_d.flag;
        st_d.rdata[TPG_INT_EN_BIT] = st_q.int_en;
      end else if (haddr_i == TPG_OFF_PERIPH) begin
        st_d.rdata[TPG_PER_T0_BIT] = st_q.t0_en;
      end
    end
    // Pin drive; port A pin four only ever pulls low
    st_d.a_out = st_q.a_latch;
    st_d.a_oe_n = a_dir_eff;
    st_d.a_out[TPG_PIN_A4] = 1'b0;
    st_d.a_oe_n[TPG_PIN_A4] = a_dir_eff[TPG_PIN_A4] | st_q.a_latch[TPG_PIN_A4];
    st_d.ana = ana_mask;
    st_d.t0ck = pa_sync[TPG_PIN_A4];
    st_d.b_out = b_out_eff;
    st_d.b_oe_n = b_dir_eff;
    // Pull-ups only for inputs, all under one active-low bit
    st_d.pull = {BW{~st_q.option[TPG_OPT_PULLUP_N_BIT]}} & b_dir_eff;
    // Wake follows the registered flag, so it lags the flag output by one cycle
    st_d.wake = st_q.flag & st_q.int_en;
    if (!st_q.t0_en) begin
      st_d.t0ck = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers; power-up reset clears what only it may clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q.a_dir <= TPG_A_DIR_RST;
      st_q.b_dir <= TPG_B_DIR_RST;
      st_q.cfg <= TPG_CFG_RST;
      st_q.flag <= 1'b0;
      st_q.int_en <= 1'b0;
      st_q.t0_en <= 1'b0;
      st_q.pend <= 1'b0;
      st_q.addr <= '0;
      st_q.rdata <= '0;
      st_q.a_oe_n <= '1;
      st_q.b_oe_n <= '1;
      st_q.ana <= '1;
      st_q.pull <= '0;
      st_q.t0ck <= 1'b0;
      st_q.wake <= 1'b0;
      st_q.hwr <= 1'b0;
      st_q.a_out <= '0;
      st_q.b_out <= '0;
      // Latches stay as they were through a non-power reset
      if (por_i) begin
        st_q.a_latch <= '0;
        st_q.b_latch <= '0;
        st_q.b_old <= '0;
        st_q.option <= TPG_OPT_RST;
      end
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata_o = st_q.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign pa_out_o = st_q.a_out;
  assign pa_oe_n_o = st_q.a_oe_n;
  assign pa_analog_sel_o = st_q.ana;
  assign pb_out_o = st_q.b_out;
  assign pb_oe_n_o = st_q.b_oe_n;
  assign pb_pullup_o = st_q.pull;
  assign timer_zero_ext_clock_in_o = st_q.t0ck;
  assign port_change_flag_o = st_q.flag;
  assign wake_o = st_q.wake;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_a4_never_high;
    @(posedge clk_i) disable iff (rst_i) !st_q.a_oe_n[TPG_PIN_A4] |-> !pa_out_o[TPG_PIN_A4];
  endproperty
  a_a4_never_high: assert property (p_a4_never_high) else $error("pin four drives high");

  property p_pull_off_out;
    @(posedge clk_i) disable iff (rst_i) (~pb_oe_n_o != 8'h00) |-> (~pb_oe_n_o & pb_pullup_o) == 8'h00;
  endproperty
  a_pull_off_out: assert property (p_pull_off_out) else $error("pull-up while driving");

  property p_pull_follow;
    @(posedge clk_i) disable iff (rst_i) st_q.option[TPG_OPT_PULLUP_N_BIT] |=> pb_pullup_o == 8'h00;
  endproperty
  a_pull_follow: assert property (p_pull_follow) else $error("pull-up while disabled");

  property p_flag_sets;
    @(posedge clk_i) disable iff (rst_i) |mismatch |=> port_change_flag_o;
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("flag missed");

  property p_no_out_compare;
    @(posedge clk_i) disable iff (rst_i) (b_dir_eff[7:4] == 4'h0) |-> mismatch == 4'h0;
  endproperty
  a_no_out_compare: assert property (p_no_out_compare) else $error("output joined compare");

  property p_wake;
    @(posedge clk_i) disable iff (rst_i) (port_change_flag_o && st_q.int_en) |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_dir_rst;
    @(posedge clk_i) rst_i |=> (st_q.a_dir == TPG_A_DIR_RST && st_q.b_dir == TPG_B_DIR_RST);
  endproperty
  a_dir_rst: assert property (p_dir_rst) else $error("direction reset wrong");

  property p_analog_zero;
    @(posedge clk_i) disable iff (rst_i) (st_q.cfg == TPG_CFG_RST) |-> pa_read[3:0] == 4'h0;
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin reads one");

  // Pin four may only sink current when its latch and direction bits are both zero
  property p_a4_open_drain;
    @(posedge clk_i) disable iff (rst_i) !pa_oe_n_o[TPG_PIN_A4] |-> $past(st_q.a_latch[TPG_PIN_A4] | st_q.a_dir[TPG_PIN_A4]) == 1'b0;
  endproperty
  a_a4_open_drain: assert property (p_a4_open_drain) else $error("pin four driven while released");

  property p_rdata_upper_zero;
    @(posedge clk_i) disable iff (rst_i) hrdata_o[31:8] == 24'h000000;
  endproperty
  a_rdata_upper_zero: assert property (p_rdata_upper_zero) else $error("unused read bits set");

  // A port B read, then the reference holds what the pins showed at that read
  sequence s_pb_read;
    rd_now && st_q.addr == TPG_OFF_PORT_B_DATA;
  endsequence
  sequence s_ref_taken;
    st_q.b_old == $past(pb_sync[7:4]);
  endsequence
  property p_pb_relatch;
    @(posedge clk_i) disable iff (rst_i) s_pb_read |=> s_ref_taken;
  endproperty
  a_pb_relatch: assert property (p_pb_relatch) else $error("reference not taken");

  property p_per_out;
    @(posedge clk_i) disable iff (rst_i) (|(pb_per_en_i & pb_per_oe_i)) |=> (pb_oe_n_o & $past(pb_per_en_i & pb_per_oe_i)) == 8'h00;
  endproperty
  a_per_out: assert property (p_per_out) else $error("override did not drive");

  property p_wake_only_flag;
    @(posedge clk_i) disable iff (rst_i) wake_o |-> $past(port_change_flag_o && st_q.int_en);
  endproperty
  a_wake_only_flag: assert property (p_wake_only_flag) else $error("wake without flag");

  property p_t0_off;
    @(posedge clk_i) disable iff (rst_i) !st_q.t0_en |=> !timer_zero_ext_clock_in_o;
  endproperty
  a_t0_off: assert property (p_t0_off) else $error("timer clock while disabled");
endmodule : tpg_gpio

// ---- logic/tpg_pkg.sv ----
package tpg_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TPG_OFF_PORT_A_DATA = 8'h00;
  localparam logic [7:0] TPG_OFF_PORT_A_DIR = 8'h04;
  localparam logic [7:0] TPG_OFF_ANALOG_CFG = 8'h08;
  localparam logic [7:0] TPG_OFF_PORT_B_DATA = 8'h0C;
  localparam logic [7:0] TPG_OFF_PORT_B_DIR = 8'h10;
  localparam logic [7:0] TPG_OFF_OPTION = 8'h14;
  localparam logic [7:0] TPG_OFF_INT_CTRL = 8'h18;
  localparam logic [7:0] TPG_OFF_PERIPH = 8'h1C;
  // ----------------------------------------------------------------
  // Widths, fields and reset values
  // ----------------------------------------------------------------
  localparam int TPG_A_W = 5;
  localparam int TPG_B_W = 8;
  localparam int TPG_CFG_W = 3;
  localparam int TPG_ANA_PINS = 4;
  localparam int TPG_PIN_A4 = 4;
  localparam int TPG_OPT_PULLUP_N_BIT = 7;
  localparam int TPG_INT_FLAG_BIT = 0;
  localparam int TPG_INT_EN_BIT = 3;
  localparam int TPG_PER_T0_BIT = 0;
  localparam logic [4:0] TPG_A_DIR_RST = 5'h1F;
  localparam logic [7:0] TPG_B_DIR_RST = 8'hFF;
  localparam logic [2:0] TPG_CFG_RST = 3'h0;
  localparam logic [2:0] TPG_CFG_ALL_DIGITAL = 3'h6;
  localparam logic [7:0] TPG_OPT_RST = 8'hFF;
  localparam logic [1:0] TPG_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] TPG_HSIZE_WORD = 3'h2;
endpackage : tpg_pkg

// ---- logic/tpg_sync3.sv ----
// Three-stage synchroniser: the output changes once stages two and three agree
module tpg_sync3 #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } tpg_sync_t;
  tpg_sync_t st_q, st_d;

  // ----------------------------------------------------------------
  // Next state; stage one is read only by stage two
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.s1 = d_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.q[i] = st_q.s3[i];
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.q;
endmodule : tpg_sync3
